/* File: inc/cto_pkg.sv */
// Shared constants for the CAN timeout and status flag block
package cto_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CORE_CTRL = 8'h18;
  localparam logic [7:0] OFS_TIMEOUT_CFG = 8'h28;
  localparam logic [7:0] OFS_TIMEOUT_VAL = 8'h2C;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h50;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h54;
  localparam logic [7:0] OFS_RX_FIFO1_CFG = 8'hB0;

  // Reset values
  localparam logic [31:0] RST_TIMEOUT_CFG = 32'hFFFF0000;
  localparam logic [2:0] RST_CORE_CTRL = 3'h1;
  localparam logic [31:0] RST_ZERO = 32'h00000000;

  // Core control fields
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_CFG_CHANGE_BIT = 1;
  localparam int CTRL_RESTRICTED_BIT = 2;

  // Timeout configuration fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_SELECT_LSB = 1;
  localparam int CFG_PERIOD_LSB = 16;
  localparam logic [31:0] CFG_WRITABLE = 32'hFFFF0007;

  // Timeout select encodings
  localparam logic [1:0] SEL_CONTINUOUS = 2'h0;
  localparam logic [1:0] SEL_TX_EVENT = 2'h1;
  localparam logic [1:0] SEL_RX_FIFO0 = 2'h2;
  localparam logic [1:0] SEL_RX_FIFO1 = 2'h3;

  // Interrupt flag positions
  localparam int FLG_TX_EVENT_WMARK = 13;
  localparam int FLG_TX_EVENT_FULL = 14;
  localparam int FLG_TX_EVENT_LOST = 15;
  localparam int FLG_TIMESTAMP_WRAP = 16;
  localparam int FLG_RAM_FAILURE = 17;
  localparam int FLG_TIMEOUT = 18;
  localparam logic [31:0] FLG_IMPLEMENTED = 32'h0007E000;

  // Receive FIFO 1 start address keeps word bits only
  localparam logic [31:0] FIFO1_ADDR_MASK = 32'h0000FFFC;

endpackage : cto_pkg

/* File: src/cto_timeout_counter.sv */
// Timeout down-counter with continuous and FIFO-controlled modes
`timescale 1ns/10ps
module cto_timeout_counter (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Configuration
  input wire logic enable_in,
  input wire logic [1:0] select_in,
  input wire logic [15:0] period_in,
  // Reload and FIFO levels
  input wire logic reload_in,
  input wire logic tx_event_empty_in,
  input wire logic rx_fifo0_empty_in,
  input wire logic rx_fifo1_empty_in,
  // Results
  output logic [15:0] count_out,
  output logic expired_out
);
  import cto_pkg::*;

  // Whole state of the counter
  typedef struct packed {
    logic [15:0] count;
    logic expired;
  } cto_cnt_s;

  cto_cnt_s s_q;
  cto_cnt_s s_d;
  logic fifo_empty; // Empty flag of the selected FIFO

  // Pick the controlling FIFO
  always_comb begin
    case (select_in)
      SEL_TX_EVENT: fifo_empty = tx_event_empty_in;
      SEL_RX_FIFO0: fifo_empty = rx_fifo0_empty_in;
      SEL_RX_FIFO1: fifo_empty = rx_fifo1_empty_in;
      default: fifo_empty = 1'b0;
    endcase
  end

  // Next counter value
  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    if (!enable_in) begin
      // Disabled counter parks at the period
      s_d.count = period_in;
    end else if (select_in == SEL_CONTINUOUS && reload_in) begin
      s_d.count = period_in;
    end else if (select_in != SEL_CONTINUOUS && fifo_empty) begin
      // Empty FIFO presets; first stored element starts the count
      s_d.count = period_in;
    end else if (s_q.count != 16'h0000) begin
      s_d.count = s_q.count - 16'h0001;
      // Zero reached: pulse once, then sit at zero
      s_d.expired = (s_q.count == 16'h0001);
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_q.count <= RST_TIMEOUT_CFG[31:16];
      s_q.expired <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_out = s_q.count;
  assign expired_out = s_q.expired;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_cnt_disabled_park: assert property (!enable_in |=> count_out == $past(period_in))
    else $error("disabled counter not at period");
  chk_cnt_fifo_hold: assert property (
    enable_in && select_in != SEL_CONTINUOUS && fifo_empty |=> count_out == $past(period_in))
    else $error("empty fifo did not preset counter");
  chk_cnt_continuous_timeout_reload: assert property (
    enable_in && select_in == SEL_CONTINUOUS && reload_in |=> count_out == $past(period_in))
    else $error("continuous reload missed");
  chk_cnt_zero_hold: assert property (
    enable_in && select_in == SEL_CONTINUOUS && !reload_in && count_out == 16'h0000
    |=> count_out == 16'h0000)
    else $error("counter left zero without reload");
  chk_cnt_count_down: assert property (
    enable_in && select_in == SEL_CONTINUOUS && !reload_in && count_out != 16'h0000
    |=> count_out == $past(count_out) - 16'h0001
        && expired_out == ($past(count_out) == 16'h0001))
    else $error("countdown or expiry wrong");

endmodule : cto_timeout_counter

/* File: src/cto_top.sv */
// Timeout counter, message RAM status flags and their register file
`timescale 1ns/10ps

// What this block does
// - Config writes need init and change-enable set
// - Period field upper half is counter start
// - Select field picks continuous or FIFO control
// - Continuous mode: value write reloads counter
// - FIFO mode: empty holds period, stored starts
// - Enable bit gates the timeout counter
// - Timeout-occurred flag at bit 18
// - Late filtering aborted on next arbitration
// - Failed message RAM write aborts storage
// - Aborted store: no put index, no new-data
// - Late transmit read aborts, enters restricted
// - Timestamp wrap sets bit 16
// - Lost or zero-size event write sets bit 15
// - Bit 14 follows event FIFO full
// - Bit 13 set when fill reaches watermark
// - FIFO 1 start address: word bits only
module cto_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [cto_pkg::ADDR_W-1:0] addr_in,
  input wire logic [cto_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [cto_pkg::DATA_W-1:0] rd_data_out,
  // FIFO state from the message handlers
  input wire logic tx_event_empty_in,
  input wire logic rx_fifo0_empty_in,
  input wire logic rx_fifo1_empty_in,
  input wire logic [5:0] tx_event_size_in,
  input wire logic [5:0] tx_event_fill_in,
  input wire logic [5:0] tx_event_wmark_in,
  // Handler events, one-cycle pulses
  input wire logic tx_event_write_in,
  input wire logic tx_event_lost_in,
  input wire logic timestamp_wrap_in,
  input wire logic rx_busy_in,
  input wire logic arb_field_done_in,
  input wire logic rx_write_fail_in,
  input wire logic rx_store_done_in,
  input wire logic tx_read_late_in,
  // Handler controls
  output logic rx_abort_out,
  output logic store_commit_out,
  output logic tx_abort_out,
  output logic restricted_out,
  output logic init_out,
  output logic [15:0] rx_fifo1_start_address_out,
  output logic irq_out
);
  import cto_pkg::*;

  // Whole register state of the block
  typedef struct packed {
    logic [2:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] flags;
    logic [31:0] mask;
    logic [31:0] fifo1_cfg;
    // Read data register, zero outside the answer cycle
    logic [31:0] rdata;
    logic rx_abort;
    logic store_commit;
    logic tx_abort;
    logic irq;
  } cto_top_s;

  cto_top_s s_q;
  cto_top_s s_d;
  logic [15:0] timeout_count; // Live counter value
  logic timeout_expired; // Counter just reached zero
  logic val_write; // Software wrote the counter value register
  logic cfg_unlocked; // Config register may be written
  logic tx_event_full; // Event FIFO holds size elements
  logic tx_event_wmark; // Event FIFO at or above watermark
  logic rx_abort_now; // Receive work aborted this cycle
  logic [31:0] flag_set; // Hardware set requests
  logic [31:0] flag_clr; // Software write-one-to-clear

  // Address match helper, used by every decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Counter runs in its own module
  cto_timeout_counter cto_timeout_counter_inst (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .enable_in(s_q.cfg[CFG_ENABLE_BIT]),
    .select_in(s_q.cfg[CFG_SELECT_LSB +: 2]),
    .period_in(s_q.cfg[CFG_PERIOD_LSB +: 16]),
    .reload_in(val_write),
    .tx_event_empty_in(tx_event_empty_in),
    .rx_fifo0_empty_in(rx_fifo0_empty_in),
    .rx_fifo1_empty_in(rx_fifo1_empty_in),
    .count_out(timeout_count),
    .expired_out(timeout_expired)
  );

  // Event FIFO level conditions and write strobes
  always_comb begin
    // Zero-size FIFO never counts as full
    tx_event_full = (tx_event_size_in != 6'h00) && (tx_event_fill_in >= tx_event_size_in);
    // Watermark zero means the watermark is off
    tx_event_wmark = (tx_event_wmark_in != 6'h00) && (tx_event_fill_in >= tx_event_wmark_in);
    // A write to the value register is the continuous-mode reload
    val_write = wr_in && hit(addr_in, OFS_TIMEOUT_VAL);
    cfg_unlocked = s_q.ctrl[CTRL_INIT_BIT] && s_q.ctrl[CTRL_CFG_CHANGE_BIT];
    // Next arbitration field caught the receive handler still busy, or a message RAM write failed
    rx_abort_now = (arb_field_done_in && rx_busy_in) || rx_write_fail_in;
  end

  // Hardware flag sources
  always_comb begin
    flag_set = RST_ZERO;
    flag_set[FLG_TIMEOUT] = timeout_expired;
    flag_set[FLG_RAM_FAILURE] = rx_abort_now || tx_read_late_in;
    flag_set[FLG_TIMESTAMP_WRAP] = timestamp_wrap_in;
    // Lost element, or any write into an event FIFO of size zero
    flag_set[FLG_TX_EVENT_LOST] = tx_event_lost_in ||
      (tx_event_write_in && tx_event_size_in == 6'h00);
    flag_set[FLG_TX_EVENT_WMARK] = tx_event_wmark;
    // Ones written to the flag register clear those bits, zeros leave them
    flag_clr = (wr_in && hit(addr_in, OFS_IRQ_FLAGS)) ? wr_data_in : RST_ZERO;
  end

  // Next state of every register
  always_comb begin
    // Start from the held value; each branch below moves one field.
    // Software writes come first, hardware sets after, so hardware wins.
    s_d = s_q;

    // Core control: software bits, hardware may set restricted
    if (wr_in && hit(addr_in, OFS_CORE_CTRL)) begin
      s_d.ctrl = wr_data_in[2:0];
    end
    if (tx_read_late_in) begin
      // Set beats a simultaneous software clear
      s_d.ctrl[CTRL_RESTRICTED_BIT] = 1'b1;
    end

    // Timeout config only while unlocked; other writes dropped
    if (wr_in && hit(addr_in, OFS_TIMEOUT_CFG) && cfg_unlocked) begin
      s_d.cfg = wr_data_in & CFG_WRITABLE;
    end

    // Sticky flags: clear first, so a same-cycle set wins
    s_d.flags = ((s_q.flags & ~flag_clr) | flag_set) & FLG_IMPLEMENTED;
    // Full is a live level, not sticky
    s_d.flags[FLG_TX_EVENT_FULL] = tx_event_full;

    if (wr_in && hit(addr_in, OFS_IRQ_MASK)) begin
      s_d.mask = wr_data_in & FLG_IMPLEMENTED;
    end

    // Start address keeps word bits, low bits read zero
    if (wr_in && hit(addr_in, OFS_RX_FIFO1_CFG)) begin
      s_d.fifo1_cfg = wr_data_in & FIFO1_ADDR_MASK;
    end

    // Handler controls, one cycle after their cause
    s_d.rx_abort = rx_abort_now;
    // An aborted store never advances the put index or new-data
    s_d.store_commit = rx_store_done_in && !rx_abort_now;
    s_d.tx_abort = tx_read_late_in;

    // Level interrupt from the values being registered
    s_d.irq = |(s_d.flags & s_d.mask);

    // Read data stands only in the cycle after the strobe
    s_d.rdata = RST_ZERO;
    if (rd_in) begin
      if (hit(addr_in, OFS_CORE_CTRL)) begin
        s_d.rdata = {29'h0, s_q.ctrl};
      end else if (hit(addr_in, OFS_TIMEOUT_CFG)) begin
        s_d.rdata = s_q.cfg;
      end else if (hit(addr_in, OFS_TIMEOUT_VAL)) begin
        // Live count, so two reads in a row may differ
        s_d.rdata = {16'h0000, timeout_count};
      end else if (hit(addr_in, OFS_IRQ_FLAGS)) begin
        // Full bit is the live level, the others are sticky
        s_d.rdata = s_q.flags;
      end else if (hit(addr_in, OFS_IRQ_MASK)) begin
        s_d.rdata = s_q.mask;
      end else if (hit(addr_in, OFS_RX_FIFO1_CFG)) begin
        s_d.rdata = s_q.fifo1_cfg;
      end else begin
        // Unmapped reads return zero
        s_d.rdata = RST_ZERO;
      end
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      // Init comes up set, so config stays locked until change-enable
      s_q.ctrl <= RST_CORE_CTRL;
      s_q.cfg <= RST_TIMEOUT_CFG;
      s_q.flags <= RST_ZERO;
      s_q.mask <= RST_ZERO;
      s_q.fifo1_cfg <= RST_ZERO;
      s_q.rdata <= RST_ZERO;
      s_q.rx_abort <= 1'b0;
      s_q.store_commit <= 1'b0;
      s_q.tx_abort <= 1'b0;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  assign rd_data_out = s_q.rdata;
  assign rx_abort_out = s_q.rx_abort;
  assign store_commit_out = s_q.store_commit;
  assign tx_abort_out = s_q.tx_abort;
  assign restricted_out = s_q.ctrl[CTRL_RESTRICTED_BIT];
  assign init_out = s_q.ctrl[CTRL_INIT_BIT];
  assign rx_fifo1_start_address_out = s_q.fifo1_cfg[15:0];
  assign irq_out = s_q.irq;

  // Checks sleep through reset; each names the rule it guards.
  // Most look one edge after their cause, at the registered answer,
  // because every output here comes from the state register.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_cfg_write_lock: assert property (
    wr_in && hit(addr_in, OFS_TIMEOUT_CFG) && !cfg_unlocked |=> $stable(s_q.cfg))
    else $error("locked config register changed");
  chk_cfg_write_take: assert property (
    wr_in && hit(addr_in, OFS_TIMEOUT_CFG) && cfg_unlocked
    |=> s_q.cfg == ($past(wr_data_in) & CFG_WRITABLE))
    else $error("unlocked config write lost");
  chk_timeout_flag_set: assert property (
    timeout_expired |=> s_q.flags[FLG_TIMEOUT])
    else $error("timeout flag not set on expiry");
  chk_rx_late_abort: assert property (
    arb_field_done_in && rx_busy_in |=> rx_abort_out && s_q.flags[FLG_RAM_FAILURE])
    else $error("late receive work not aborted");
  chk_rx_fail_abort: assert property (
    rx_write_fail_in |=> rx_abort_out && s_q.flags[FLG_RAM_FAILURE])
    else $error("failed ram write not flagged");
  chk_store_commit_hold: assert property (
    rx_store_done_in && rx_write_fail_in |=> !store_commit_out)
    else $error("aborted store committed");
  chk_tx_fail_restrict: assert property (
    tx_read_late_in |=> tx_abort_out && restricted_out && s_q.flags[FLG_RAM_FAILURE])
    else $error("late transmit read mishandled");
  chk_wrap_flag_set: assert property (
    timestamp_wrap_in |=> s_q.flags[FLG_TIMESTAMP_WRAP])
    else $error("timestamp wrap not flagged");
  chk_lost_zero_size: assert property (
    tx_event_write_in && tx_event_size_in == 6'h00 |=> s_q.flags[FLG_TX_EVENT_LOST])
    else $error("zero-size event write not flagged");
  chk_full_flag_track: assert property (
    ##1 s_q.flags[FLG_TX_EVENT_FULL] == $past(tx_event_full))
    else $error("full flag does not follow fifo");
  chk_wmark_flag_set: assert property (
    tx_event_wmark |=> s_q.flags[FLG_TX_EVENT_WMARK])
    else $error("watermark flag not set");
  chk_fifo1_addr_low: assert property (
    rx_fifo1_start_address_out[1:0] == 2'h0)
    else $error("start address low bits not zero");

  // Control register and start address as software sees them
  chk_restrict_leave: assert property (
    wr_in && hit(addr_in, OFS_CORE_CTRL) && !wr_data_in[CTRL_RESTRICTED_BIT]
    && !tx_read_late_in |=> !restricted_out)
    else $error("restricted mode not left on clear");
  chk_restrict_hold: assert property (
    restricted_out && !(wr_in && hit(addr_in, OFS_CORE_CTRL)) |=> restricted_out)
    else $error("restricted mode left without a clear");
  chk_init_follow: assert property (
    wr_in && hit(addr_in, OFS_CORE_CTRL) |=> init_out == $past(wr_data_in[CTRL_INIT_BIT]))
    else $error("init bit not written");
  chk_fifo1_addr_take: assert property (
    wr_in && hit(addr_in, OFS_RX_FIFO1_CFG)
    |=> {16'h0000, rx_fifo1_start_address_out} == ($past(wr_data_in) & FIFO1_ADDR_MASK))
    else $error("start address write lost");

  // Handler pulses appear only after their cause, for one cycle
  chk_tx_abort_idle: assert property (
    !tx_read_late_in |=> !tx_abort_out)
    else $error("transmit abort without cause");
  chk_rx_abort_idle: assert property (
    !rx_abort_now |=> !rx_abort_out)
    else $error("receive abort without cause");
  chk_store_commit_pass: assert property (
    rx_store_done_in && !rx_abort_now |=> store_commit_out)
    else $error("clean store not committed");
  chk_commit_idle: assert property (
    !rx_store_done_in |=> !store_commit_out)
    else $error("commit without a finished store");

  // Sticky flags: raised by their event, dropped only by a written one; full stays a live level
  chk_lost_flag_set: assert property (
    tx_event_lost_in |=> s_q.flags[FLG_TX_EVENT_LOST])
    else $error("lost element not flagged");
  chk_lost_size_ok: assert property (
    tx_event_write_in && tx_event_size_in != 6'h00 && !tx_event_lost_in
    && !s_q.flags[FLG_TX_EVENT_LOST] |=> !s_q.flags[FLG_TX_EVENT_LOST])
    else $error("lost flag set by a normal event write");
  chk_timeout_flag_clr: assert property (
    wr_in && hit(addr_in, OFS_IRQ_FLAGS) && wr_data_in[FLG_TIMEOUT] && !timeout_expired
    |=> !s_q.flags[FLG_TIMEOUT])
    else $error("timeout flag not cleared");
  chk_timeout_flag_hold: assert property (
    s_q.flags[FLG_TIMEOUT] && !(wr_in && hit(addr_in, OFS_IRQ_FLAGS))
    |=> s_q.flags[FLG_TIMEOUT])
    else $error("timeout flag dropped without a clear");
  chk_ram_flag_hold: assert property (
    s_q.flags[FLG_RAM_FAILURE] && !(wr_in && hit(addr_in, OFS_IRQ_FLAGS))
    |=> s_q.flags[FLG_RAM_FAILURE])
    else $error("ram failure flag dropped without a clear");
  chk_wmark_flag_clr: assert property (
    wr_in && hit(addr_in, OFS_IRQ_FLAGS) && wr_data_in[FLG_TX_EVENT_WMARK] && !tx_event_wmark
    |=> !s_q.flags[FLG_TX_EVENT_WMARK])
    else $error("watermark flag kept below watermark");
  chk_full_no_size: assert property (
    tx_event_size_in == 6'h00 |=> !s_q.flags[FLG_TX_EVENT_FULL])
    else $error("zero-size fifo reported full");

  // Bus and interrupt line
  chk_read_idle_zero: assert property (
    !rd_in |=> rd_data_out == RST_ZERO)
    else $error("read data outside its cycle");
  chk_irq_mask_off: assert property (
    wr_in && hit(addr_in, OFS_IRQ_MASK) && wr_data_in == RST_ZERO |=> !irq_out)
    else $error("interrupt with every source masked");

  cov_timeout_expiry: cover property (timeout_expired ##1 irq_out);
  cov_tx_restricted: cover property (tx_read_late_in ##1 restricted_out);
  cov_rx_abort: cover property (arb_field_done_in && rx_busy_in ##1 rx_abort_out);
  cov_cfg_write: cover property (wr_in && hit(addr_in, OFS_TIMEOUT_CFG) && cfg_unlocked);
  cov_lost_zero_size: cover property (tx_event_write_in && tx_event_size_in == 6'h00 ##1 irq_out);

endmodule : cto_top

/* File: bench/cto_handler_model.sv */
// Stand-in for the message handlers that feed event pulses to the block
`timescale 1ns/10ps
module cto_handler_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Bench command, one bit per handler event
  input wire logic [7:0] cmd_in,
  // Event lines towards the block
  output logic [7:0] ev_out
);
  // One register stage, so each event follows its command one cycle later
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ev_out <= 8'h00;
    end else begin
      ev_out <= cmd_in;
    end
  end
endmodule : cto_handler_model

/* File: bench/cto_top_tb.sv */
// Self-checking bench for the timeout counter and status flag block
`timescale 1ns/10ps
module cto_top_tb;
  import cto_pkg::*;
  logic clk_in = 1'b0; // 200 MHz clock
  logic rst_b_in = 1'b0; // Synchronous reset
  logic [7:0] addr = 8'h00; // Register bus
  logic [31:0] wdat = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdat;
  logic [2:0] emp = 3'h7; // Empty: event FIFO, FIFO 0, FIFO 1
  logic [5:0] size = 6'h00; // Event FIFO geometry
  logic [5:0] fill = 6'h00;
  logic [5:0] wm = 6'h00;
  logic [7:0] cmd = 8'h00; // Handler event requests
  logic [7:0] ev;
  logic ab, cm, tab, rs, ini, irq;
  logic [15:0] f1a;
  logic rd_seen = 1'b0; // Read data due this cycle
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic [31:0] seed = 32'hABBD;
  logic [31:0] d;
  int mismatches = 0;
  int check_count = 0;
  int n;

  // Free-running clock
  always #2.5 clk_in = ~clk_in;

  cto_top cto_top_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
    .tx_event_empty_in(emp[0]), .rx_fifo0_empty_in(emp[1]), .rx_fifo1_empty_in(emp[2]),
    .tx_event_size_in(size), .tx_event_fill_in(fill), .tx_event_wmark_in(wm),
    .tx_event_write_in(ev[0]), .tx_event_lost_in(ev[1]), .timestamp_wrap_in(ev[2]),
    .rx_busy_in(ev[3]), .arb_field_done_in(ev[4]), .rx_write_fail_in(ev[5]),
    .rx_store_done_in(ev[6]), .tx_read_late_in(ev[7]), .rx_abort_out(ab),
    .store_commit_out(cm), .tx_abort_out(tab), .restricted_out(rs), .init_out(ini),
    .rx_fifo1_start_address_out(f1a), .irq_out(irq));

  cto_handler_model cto_handler_model_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .cmd_in(cmd), .ev_out(ev));

  // Random source for register contents and fill levels
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // One-cycle write strobe
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    wdat <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr32

  // One-cycle read strobe; expectation goes to the queue
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd <= 1'b0;
  endtask : rd32

  // Event through the handler model; outputs settled on return
  task automatic fire(input logic [7:0] c);
    @(posedge clk_in);
    cmd <= c;
    @(posedge clk_in);
    cmd <= 8'h00;
    @(posedge clk_in);
    #1;
  endtask : fire

  // Cycles until the interrupt rises, bounded
  task automatic wait_irq(input int base, input int e);
    n = base;
    #1;
    while (irq !== 1'b1) begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > 300) begin
        mismatches++;
        summarize();
      end
    end
    chk(n, e);
  endtask : wait_irq

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_in) rd_seen <= rd;
  always @(negedge clk_in) begin
    if (rd_seen) begin
      chk(rdat, exp_q.pop_front());
    end
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd32(OFS_TIMEOUT_CFG, RST_TIMEOUT_CFG);
    rd32(OFS_TIMEOUT_VAL, 32'h0000FFFF);
    rd32(OFS_CORE_CTRL, 32'h00000001);
    rd32(OFS_IRQ_FLAGS, RST_ZERO);
    rd32(8'h04, RST_ZERO);
    chk(ini, 1'b1);
    $display("test reset values done");
    // Refused while change enable is clear
    wr32(OFS_TIMEOUT_CFG, 32'h00140001);
    rd32(OFS_TIMEOUT_CFG, RST_TIMEOUT_CFG);
    wr32(OFS_CORE_CTRL, 32'h00000003);
    d = xs() & 32'hFFFFFFFE;
    wr32(OFS_TIMEOUT_CFG, d);
    rd32(OFS_TIMEOUT_CFG, d & CFG_WRITABLE);
    d = xs();
    wr32(OFS_RX_FIFO1_CFG, d);
    rd32(OFS_RX_FIFO1_CFG, d & FIFO1_ADDR_MASK);
    chk({16'h0000, f1a}, d & FIFO1_ADDR_MASK);
    wr32(OFS_IRQ_MASK, FLG_IMPLEMENTED);
    $display("test config access done");
    // Continuous mode, period 20
    wr32(OFS_TIMEOUT_CFG, 32'h00140001);
    wr32(OFS_TIMEOUT_VAL, 32'h00000000);
    wr32(OFS_IRQ_FLAGS, 32'h00040000);
    wait_irq(2, 21);
    rd32(OFS_TIMEOUT_VAL, RST_ZERO);
    rd32(OFS_IRQ_FLAGS, 32'h00040000);
    wr32(OFS_TIMEOUT_CFG, 32'h00140000);
    rd32(OFS_TIMEOUT_VAL, 32'h00000014);
    $display("test continuous done");
    // Each FIFO mode: only the selected FIFO starts the count
    for (int s = 1; s < 4; s++) begin
      // Selected FIFO empty, the other two holding data
      @(posedge clk_in);
      emp <= 3'h1 << (s - 1);
      wr32(OFS_TIMEOUT_CFG, 32'h00140001 | (s << 1));
      wr32(OFS_IRQ_FLAGS, 32'h00040000);
      repeat (30) @(posedge clk_in);
      rd32(OFS_TIMEOUT_VAL, 32'h00000014);
      @(posedge clk_in);
      emp <= 3'h0;
      wait_irq(0, 21);
    end
    @(posedge clk_in);
    emp <= 3'h7;
    $display("test fifo modes done");
    // Handler events
    wr32(OFS_IRQ_FLAGS, FLG_IMPLEMENTED);
    fire(8'h80);
    chk({tab, rs}, 2'b11);
    rd32(OFS_CORE_CTRL, 32'h00000007);
    rd32(OFS_IRQ_FLAGS, 32'h00020000);
    wr32(OFS_CORE_CTRL, 32'h00000003);
    #1;
    chk(rs, 1'b0);
    fire(8'h40);
    chk({ab, cm}, 2'b01);
    fire(8'h60);
    chk({ab, cm}, 2'b10);
    fire(8'h58);
    chk({ab, cm}, 2'b10);
    fire(8'h50);
    chk({ab, cm}, 2'b01);
    size <= 6'h04;
    wr32(OFS_IRQ_FLAGS, FLG_IMPLEMENTED);
    fire(8'h05);
    rd32(OFS_IRQ_FLAGS, 32'h00010000);
    size <= 6'h00;
    fire(8'h01);
    rd32(OFS_IRQ_FLAGS, 32'h00018000);
    wr32(OFS_IRQ_FLAGS, 32'h00008000);
    fire(8'h02);
    rd32(OFS_IRQ_FLAGS, 32'h00018000);
    $display("test handler events done");
    // Full and watermark against random fill levels
    size <= 6'h08;
    wm <= 6'h04;
    for (int i = 0; i < 6; i++) begin
      fill <= 6'(xs() % 9);
      wr32(OFS_IRQ_FLAGS, FLG_IMPLEMENTED);
      d = (fill >= 6'h08 ? 32'h00004000 : 32'h0) | (fill >= 6'h04 ? 32'h00002000 : 32'h0);
      rd32(OFS_IRQ_FLAGS, d);
    end
    fill <= 6'h08;
    wr32(OFS_IRQ_MASK, RST_ZERO);
    #1;
    chk(irq, 1'b0);
    wr32(OFS_IRQ_MASK, 32'h00004000);
    #1;
    chk(irq, 1'b1);
    $display("test fifo level flags done");
    repeat (3) @(posedge clk_in);
    summarize();
  end
endmodule : cto_top_tb
